// [inc/bpa_pkg.sv]
package bpa_pkg;

  // ==========================================================================
  // Register addresses in the I/O space
  localparam logic [7:0] ADDR_PIN_DATA = 8'h38;
  localparam logic [7:0] ADDR_XSEL     = 8'h3C;
  localparam logic [7:0] ADDR_ALT_FN   = 8'h3D;
  localparam logic [7:0] ADDR_ODRAIN   = 8'h3E;
  localparam logic [7:0] ADDR_DIR      = 8'h3F;

  // ==========================================================================
  // Field positions and masks
  localparam int         XSEL_LO_LSB   = 0;
  localparam int         XSEL_HI_LSB   = 4;
  localparam logic [7:0] ALT_FN_MASK   = 8'hF3;
  localparam int         ALT_SCLK_D    = 0;
  localparam int         ALT_SCLK_C    = 1;
  localparam int         ALT_PWM_LSB   = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [1:0] XSEL_RESET    = 2'h0;
  localparam logic [7:0] REG_CLEAR     = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ==========================================================================
  // Transfer clock sources
  typedef enum logic [1:0] {
    XSRC_HALF = 2'h0,
    XSRC_TA1  = 2'h1,
    XSRC_TB1  = 2'h2,
    XSRC_TB2  = 2'h3
  } bpa_xsrc_t;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int HALF_PERIOD_NS = 2 * CLK_PERIOD_NS;
  localparam int HALF_DIV       = HALF_PERIOD_NS / CLK_PERIOD_NS;

endpackage : bpa_pkg

// [inc/bpa_xfer_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface bpa_xfer_if;
  import bpa_pkg::*;
  bpa_xsrc_t  xsel;
  logic       half_tick;
  logic [2:0] tmr;
  logic       pulse;

  modport ctl (output xsel, output half_tick, output tmr, input pulse);
  modport sel (input xsel, input half_tick, input tmr, output pulse);
endinterface : bpa_xfer_if

`default_nettype wire

// [hdl/bpa_xfer_sel.sv]
`timescale 1ns/10ps
`default_nettype none

module bpa_xfer_sel
  import bpa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Transfer clock selection
  bpa_xfer_if.sel  xf
);

  // ==========================================================================
  // Timer history for rising edge detection
  // All three are tracked so a change of select never sees a stale history
  logic [2:0] tmr_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_q <= 3'h0;
    end else begin
      tmr_q <= xf.tmr;
    end
  end

  // ==========================================================================
  // Selected transfer edge
  always_comb begin
    unique case (xf.xsel)
      XSRC_HALF: xf.pulse = xf.half_tick;
      XSRC_TA1:  xf.pulse = xf.tmr[0] & ~tmr_q[0];
      XSRC_TB1:  xf.pulse = xf.tmr[1] & ~tmr_q[1];
      XSRC_TB2:  xf.pulse = xf.tmr[2] & ~tmr_q[2];
    endcase
  end

endmodule : bpa_xfer_sel

`default_nettype wire

// [hdl/bpa_port.sv]
`timescale 1ns/10ps
`default_nettype none

module bpa_port
  import bpa_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // I/O register access
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output var  logic [7:0] io_rdata,
  // Transfer clock timers
  input  wire logic       timer_a1,
  input  wire logic       timer_b1,
  input  wire logic       timer_b2,
  // Alternate peripheral outputs
  input  wire logic       sclk_c,
  input  wire logic       sclk_d,
  input  wire logic       sclk_c_int,
  input  wire logic       sclk_d_int,
  input  wire logic [3:0] pwm,
  // Port pins
  input  wire logic [7:0] pad_in,
  output var  logic [7:0] pad_out,
  output var  logic [7:0] pad_oe,
  // Quadrature decoder inputs
  output var  logic       qd1_i,
  output var  logic       qd1_q,
  output var  logic       qd2_i,
  output var  logic       qd2_q
);

  // ==========================================================================
  // Registers
  logic [7:0] line_direction;
  logic [7:0] open_drain_select;
  logic [7:0] alternate_function_enable;
  logic [7:0] out_buf;
  logic [7:0] out_reg;
  bpa_xsrc_t  xsel_lo;
  bpa_xsrc_t  xsel_hi;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic       half_tick;

  function automatic logic wr_hit(input logic [7:0] a);
    return io_wr && (io_addr == a);
  endfunction : wr_hit

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_direction <= DIR_RESET;
    end else if (wr_hit(ADDR_DIR)) begin
      line_direction <= io_wdata;
    end
  end

  // No documented reset value; cleared so the pins start in a known mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      open_drain_select         <= REG_CLEAR;
      alternate_function_enable <= REG_CLEAR;
    end else begin
      if (wr_hit(ADDR_ODRAIN)) begin
        open_drain_select <= io_wdata;
      end
      if (wr_hit(ADDR_ALT_FN)) begin
        alternate_function_enable <= io_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      xsel_lo <= bpa_xsrc_t'(XSEL_RESET);
      xsel_hi <= bpa_xsrc_t'(XSEL_RESET);
    end else if (wr_hit(ADDR_XSEL)) begin
      // Bits 3:2 and 7:6 are never stored
      xsel_lo <= bpa_xsrc_t'(io_wdata[XSEL_LO_LSB +: 2]);
      xsel_hi <= bpa_xsrc_t'(io_wdata[XSEL_HI_LSB +: 2]);
    end
  end

  // ==========================================================================
  // Transfer clocks, one selector per nibble
  bpa_xfer_if xf_lo ();
  bpa_xfer_if xf_hi ();

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      half_tick <= 1'b0;
    end else begin
      half_tick <= ~half_tick;
    end
  end

  assign xf_lo.xsel      = xsel_lo;
  assign xf_hi.xsel      = xsel_hi;
  assign xf_lo.half_tick = half_tick;
  assign xf_hi.half_tick = half_tick;
  assign xf_lo.tmr       = {timer_b2, timer_b1, timer_a1};
  assign xf_hi.tmr       = {timer_b2, timer_b1, timer_a1};

  bpa_xfer_sel u_xsel_lo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .xf    (xf_lo.sel)
  );

  bpa_xfer_sel u_xsel_hi (
    .mclk  (mclk),
    .rst_n (rst_n),
    .xf    (xf_hi.sel)
  );

  // ==========================================================================
  // Output buffer and output register
  // A write in the same cycle as a transfer edge lands on the next edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_buf <= REG_CLEAR;
    end else if (wr_hit(ADDR_PIN_DATA)) begin
      out_buf <= io_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_reg <= REG_CLEAR;
    end else begin
      if (xf_lo.pulse) begin
        out_reg[3:0] <= out_buf[3:0];
      end
      if (xf_hi.pulse) begin
        out_reg[7:4] <= out_buf[7:4];
      end
    end
  end

  // ==========================================================================
  // Pin drive
  logic [7:0] alt_out;
  logic [7:0] fn_eff;
  logic [7:0] dir_eff;
  logic [7:0] sel_val;
  logic [7:0] next_pad_out;
  logic [7:0] next_pad_oe;

  always_comb begin
    alt_out                        = 8'h00;
    alt_out[ALT_SCLK_D]            = sclk_d;
    alt_out[ALT_SCLK_C]            = sclk_c;
    alt_out[ALT_PWM_LSB +: 4]      = pwm;
    fn_eff                         = alternate_function_enable & ALT_FN_MASK;
    sel_val                        = (fn_eff & alt_out) | (~fn_eff & out_reg);
    dir_eff                        = line_direction;
    dir_eff[ALT_SCLK_D]            = line_direction[ALT_SCLK_D] | sclk_d_int;
    dir_eff[ALT_SCLK_C]            = line_direction[ALT_SCLK_C] | sclk_c_int;
    // Open drain only pulls low; a one is left to the pull-up
    next_pad_out = sel_val & ~open_drain_select;
    next_pad_oe  = dir_eff & (~open_drain_select | ~sel_val);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pad_out <= REG_CLEAR;
      pad_oe  <= REG_CLEAR;
    end else begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
    end
  end

  // ==========================================================================
  // Pin sampling and readback
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1 <= REG_CLEAR;
      pin_s2 <= REG_CLEAR;
    end else begin
      pin_s1 <= pad_in;
      pin_s2 <= pin_s1;
    end
  end

  // Pin state is two cycles old when read; the price of a safe sample
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata <= READ_ZERO;
    end else if (io_rd && (io_addr == ADDR_PIN_DATA)) begin
      io_rdata <= pin_s2;
    end else begin
      io_rdata <= READ_ZERO;
    end
  end

  assign qd1_q = pin_s2[0];
  assign qd1_i = pin_s2[1];
  assign qd2_q = pin_s2[2];
  assign qd2_i = pin_s2[3];

  // ==========================================================================
  // Assertions
  dir_reset_a: assert property (@(posedge mclk)
    $rose(rst_n) |-> (line_direction == DIR_RESET) && (pad_oe == REG_CLEAR))
    else $error("direction not cleared by reset");

  dir_input_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (line_direction[5] == 1'b0) |=> !pad_oe[5])
    else $error("input line is driven");

  dir_output_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (line_direction[6] && !open_drain_select[6]) |=> pad_oe[6])
    else $error("push-pull output not driven");

  od_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> ((pad_out & $past(open_drain_select)) == 8'h00))
    else $error("open drain line drives high");

  pwm_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (alternate_function_enable[4] && !open_drain_select[4])
      |=> (pad_out[4] == $past(pwm[0])))
    else $error("pwm not routed to bit 4");

  fn_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!open_drain_select[2]) |=> (pad_out[2] == $past(out_reg[2])))
    else $error("bit 2 does not carry port data");

  force_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sclk_d_int && !open_drain_select[0]) |=> pad_oe[0])
    else $error("serial clock pin not forced out");

  xsel_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_hit(ADDR_XSEL) |=> (xsel_hi == $past(io_wdata[5:4]))
      && (xsel_lo == $past(io_wdata[1:0])))
    else $error("transfer select not stored");

  xfer_half_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_hit(ADDR_PIN_DATA) && xsel_lo == XSRC_HALF && xsel_hi == XSRC_HALF)
      ##1 !io_wr [*2] |-> ##[0:1] (out_reg == $past(out_buf)))
    else $error("half clock transfer missed");

  xfer_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (xsel_hi == XSRC_TB2 && !(timer_b2 && !$past(timer_b2)))
      |=> $stable(out_reg[7:4]))
    else $error("upper nibble moved without timer edge");

  xsel_reset_a: assert property (@(posedge mclk)
    $rose(rst_n) |-> (xsel_lo == XSRC_HALF) && (xsel_hi == XSRC_HALF))
    else $error("transfer select not cleared by reset");

  xfer_lo_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (xsel_lo == XSRC_TA1 && !(timer_a1 && !$past(timer_a1)))
      |=> $stable(out_reg[3:0]))
    else $error("lower nibble moved without timer edge");

  xfer_tb1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (xsel_hi == XSRC_TB1 && timer_b1 && !$past(timer_b1))
      |=> (out_reg[7:4] == $past(out_buf[7:4])))
    else $error("upper nibble missed timer edge");

  read_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_addr == ADDR_PIN_DATA) |=> (io_rdata == $past(pin_s2)))
    else $error("read does not return pin state");

  read_wo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_addr == ADDR_DIR) |=> (io_rdata == READ_ZERO))
    else $error("write-only register readable");

  quad_in_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> ##1 (qd1_i == $past(pad_in[1], 2)) && (qd2_q == $past(pad_in[2], 2)))
    else $error("decoder input not from pin");

  tb1_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
    xsel_lo == XSRC_TB1 && xf_lo.pulse);

  od_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
    line_direction[0] && open_drain_select[0] && !pad_oe[0]);

  sclk_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
    sclk_c_int && alternate_function_enable[1]);

endmodule : bpa_port

`default_nettype wire

// [testbench/bpa_pins_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Pin wiring outside the port: internal pull-ups, optional external drivers
module bpa_pins_model (
  // Device side of each pin
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // Outside circuitry
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Level seen back at the device
  output var  logic [7:0] pad_in
);
  // Contention is not modelled: the device wins where the bench drives a pin that is an output
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : bpa_pins_model

`default_nettype wire

// [testbench/bpa_port_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module bpa_port_tb;
  import bpa_pkg::*;
  // ==========================================================================
  // Signals
  logic       mclk, rst_n, io_wr, io_rd, sclk_c, sclk_d, sclk_c_int, sclk_d_int;
  logic [7:0] io_addr, io_wdata, io_rdata, pad_in, pad_out, pad_oe, ext_val, ext_en, d, prev;
  logic [7:0] dat;
  logic [3:0] pwm;
  logic [2:0] tmr;
  logic       qd1_i, qd1_q, qd2_i, qd2_q;
  int         n_mismatch, num_checks, cyc;

  bpa_port u_bpa_port (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .timer_a1(tmr[0]),
    .timer_b1(tmr[1]), .timer_b2(tmr[2]), .sclk_c(sclk_c), .sclk_d(sclk_d),
    .sclk_c_int(sclk_c_int), .sclk_d_int(sclk_d_int), .pwm(pwm), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .qd1_i(qd1_i), .qd1_q(qd1_q), .qd2_i(qd2_i),
    .qd2_q(qd2_q));
  bpa_pins_model u_bpa_pins_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // About 120 cycles are needed; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    io_addr  = a;
    io_wdata = v;
    io_wr    = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    v     = io_rdata;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, io_wr, io_rd, sclk_c, sclk_d, sclk_c_int, sclk_d_int} = '0;
    {io_addr, io_wdata, ext_val, ext_en, pwm, tmr} = '0;
    wait_n(8);
    rst_n = 1'b1;
    check("pad_oe after reset", pad_oe, 8'h00);
    wait_n(3);
    rd(ADDR_PIN_DATA, d);
    check("idle pins", d, 8'hFF);
    rd(ADDR_DIR, d);
    check("direction readback", d, 8'h00);
    wr(ADDR_DIR, 8'hFF);
    wr(ADDR_PIN_DATA, 8'hA5);
    wait_n(4);
    check("pad_out half clock", pad_out, 8'hA5);
    check("pad_oe all out", pad_oe, 8'hFF);
    wait_n(2);
    rd(ADDR_PIN_DATA, d);
    check("pin readback", d, 8'hA5);
    wr(ADDR_ODRAIN, 8'h0F);
    wait_n(2);
    check("open drain oe", pad_oe, 8'hFA);
    check("open drain out", pad_out, 8'hA0);
    wr(ADDR_ODRAIN, 8'h00);
    wr(ADDR_DIR, 8'hF0);
    ext_val = 8'h03;
    ext_en  = 8'h0F;
    wait_n(4);
    check("pad_oe mixed", pad_oe, 8'hF0);
    rd(ADDR_PIN_DATA, d);
    check("mixed readback", d, 8'hA3);
    check("decoder inputs", {4'h0, qd2_i, qd2_q, qd1_i, qd1_q}, 8'h03);
    sclk_d_int = 1'b1;
    wait_n(2);
    check("forced sclk d", pad_oe, 8'hF1);
    sclk_d_int = 1'b0;
    sclk_c_int = 1'b1;
    wait_n(2);
    check("forced sclk c", pad_oe, 8'hF2);
    sclk_c_int = 1'b0;
    ext_en     = 8'h00;
    wr(ADDR_DIR, 8'hFF);
    prev = 8'hA5;
    // Both nibbles on the same timer; ignored control bits set every time
    for (int k = 1; k < 4; k++) begin
      dat = 8'(k * 8'h35);
      wr(ADDR_XSEL, 8'hCC | 8'(k << 4) | 8'(k));
      wr(ADDR_PIN_DATA, dat);
      wait_n(6);
      check("held until timer", pad_out, prev);
      tmr = 3'(1 << (k - 1));
      wait_n(3);
      check("timer transfer", pad_out, dat);
      tmr  = 3'h0;
      prev = dat;
    end
    wr(ADDR_XSEL, 8'h10);
    wr(ADDR_PIN_DATA, 8'h0C);
    wait_n(4);
    check("nibbles independent", pad_out, {prev[7:4], 4'hC});
    wr(ADDR_XSEL, 8'h00);
    wait_n(4);
    check("back to half clock", pad_out, 8'h0C);
    pwm    = 4'h9;
    sclk_d = 1'b1;
    wr(ADDR_ALT_FN, 8'hFF);
    wait_n(3);
    check("alternate outputs", pad_out, 8'h9D);
    pwm    = 4'h6;
    sclk_d = 1'b0;
    sclk_c = 1'b1;
    sclk_c_int = 1'b1;
    wait_n(3);
    check("alternate follow", pad_out, 8'h6E);
    sclk_c_int = 1'b0;
    rd(ADDR_ALT_FN, d);
    check("function readback", d, 8'h00);
    rd(8'h40, d);
    check("unmapped read", d, 8'h00);
    wr(8'h39, 8'h00);
    wait_n(3);
    check("unmapped write", pad_out, 8'h6E);
    rst_n = 1'b0;
    wait_n(2);
    rst_n = 1'b1;
    wait_n(1);
    check("pad_oe second reset", pad_oe, 8'h00);
    conclude();
  end
endmodule : bpa_port_tb

`default_nettype wire
